// file: dcs_pkg.sv
// shared constants for the dma channel status block
package dcs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  OFF_STATE   = 8'h00;  // channel_state_register
  localparam logic [7:0]  OFF_SETUP   = 8'h04;  // channel setup (start, enables)
  localparam logic [7:0]  OFF_EV_STAT = 8'h08;  // sticky event status, write 1 clears
  localparam logic [7:0]  OFF_EV_MASK = 8'h0c;  // event mask
  localparam logic [31:0] STATE_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // channel_state_register fields
  // ----------------------------------------------------------------
  localparam int LIVE_BIT = 31;
  localparam int NC_BIT   = 23;
  localparam int ABC_BIT  = 22;
  localparam int SBE_BIT  = 20;
  localparam int DBE_BIT  = 19;
  localparam int CFG_BIT  = 18;

  // ----------------------------------------------------------------
  // channel setup fields
  // ----------------------------------------------------------------
  localparam int START_BIT  = 0;
  localparam int NC_IE_BIT  = 1;
  localparam int ABC_IE_BIT = 2;

  // ----------------------------------------------------------------
  // flag and event indices
  // ----------------------------------------------------------------
  localparam int FLAG_NC   = 0;
  localparam int FLAG_ABC  = 1;
  localparam int FLAG_SBE  = 2;
  localparam int FLAG_DBE  = 3;
  localparam int FLAG_CFG  = 4;
  localparam int NUM_FLAGS = 5;

  localparam int EV_NORMAL    = 0;
  localparam int EV_ABNORMAL  = 1;
  localparam int EV_START_ERR = 2;
  localparam int NUM_EV       = 3;

endpackage

// file: dcs_flag.sv
// one sticky status flag with set priority over clear
`timescale 1ns/100ps
`default_nettype none

module dcs_flag (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic set,
  input  wire logic clr,
  output var  logic q
);

  logic flag_r;
  logic flag_nxt;

  // a set arriving with a clear is kept, so no event is lost
  always_comb begin
    flag_nxt = flag_r;
    if (clr) begin
      flag_nxt = 1'b0;
    end
    if (set) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign q = flag_r;

  set_wins_a : assert property (@(posedge ref_clk) disable iff (!rstn)
    set |=> flag_r)
    else $error("flag lost a set");

endmodule

`default_nettype wire

// file: dcs_irq.sv
// sticky event status, mask and the level interrupt output
`timescale 1ns/100ps
`default_nettype none

module dcs_irq #(
  parameter int N = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [N-1:0] ev,
  input  wire logic         wr_stat,
  input  wire logic         wr_mask,
  input  wire logic [N-1:0] wdata,
  input  wire logic         lvl_req,
  output var  logic [N-1:0] stat_o,
  output var  logic [N-1:0] mask_o,
  output var  logic         irq_o
);

  logic [N-1:0] stat_r;
  logic [N-1:0] stat_nxt;
  logic [N-1:0] mask_r;
  logic [N-1:0] mask_nxt;
  logic         irq_r;
  logic         irq_nxt;

  // write one clears, a new event in the same cycle wins
  always_comb begin
    stat_nxt = (stat_r & ~(wr_stat ? wdata : '0)) | ev;
    mask_nxt = wr_mask ? wdata : mask_r;
    irq_nxt  = (|(stat_nxt & mask_nxt)) | lvl_req;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign stat_o = stat_r;
  assign mask_o = mask_r;
  assign irq_o  = irq_r;

  irq_level_a : assert property (@(posedge ref_clk) disable iff (!rstn)
    irq_r == ((|(stat_r & mask_r)) | $past(lvl_req)))
    else $error("interrupt level does not match status and mask");

endmodule

`default_nettype wire

// file: dcs_channel.sv
// per-channel status logic of the dma controller
//
// Notes on behaviour
// - bit 31 reads 1 while the channel is live, else 0; resets to 0.
// - normal end sets bit 23 and requests interrupt when enabled.
// - writing 0 to bit 23 clears it and its request; 1 is ignored.
// - a start while bit 23 is set is an error and starts nothing.
// - abnormal end sets bit 22 and requests interrupt when enabled.
// - writing 0 to bit 22 clears it and its request; 1 is ignored.
// - clearing bit 22 also clears bits 20, 19 and 18.
// - a start while bit 22 is set is an error and starts nothing.
// - source bus error sets read-only bit 20; resets to 0.
// - destination bus error sets read-only bit 19; resets to 0.
// - configuration error sets read-only bit 18; resets to 0.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module dcs_channel (
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  input  wire logic [dcs_pkg::ADDR_W-1:0] addr,
  input  wire logic [dcs_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output var  logic [dcs_pkg::DATA_W-1:0] rdata,
  input  wire logic                       xfer_done_i,
  input  wire logic                       src_bus_err_i,
  input  wire logic                       dst_bus_err_i,
  input  wire logic                       cfg_err_i,
  output var  logic                       start_o,
  output var  logic                       stop_o,
  output var  logic                       start_err_o,
  output var  logic                       chan_live_o,
  output var  logic                       irq_o
);

  // ----------------------------------------------------------------
  // decode and events
  // ----------------------------------------------------------------
  logic                           wr_state;
  logic                           wr_setup;
  logic                           start_req;
  logic                           any_err;
  logic                           done_ok;
  logic                           start_err;
  logic                           start_ok;
  logic [dcs_pkg::NUM_FLAGS-1:0]  flag_set;
  logic [dcs_pkg::NUM_FLAGS-1:0]  flag_clr;
  logic [dcs_pkg::NUM_FLAGS-1:0]  flag_q;
  logic [dcs_pkg::NUM_EV-1:0]     ev;
  logic [dcs_pkg::NUM_EV-1:0]     ev_stat;
  logic [dcs_pkg::NUM_EV-1:0]     ev_mask;
  logic                           lvl_req;
  logic                           irq_w;

  // register state
  logic                       live_r;
  logic                       live_nxt;
  logic                       nc_ie_r;
  logic                       nc_ie_nxt;
  logic                       abc_ie_r;
  logic                       abc_ie_nxt;
  logic                       start_r;
  logic                       start_nxt;
  logic                       stop_r;
  logic                       stop_nxt;
  logic                       serr_r;
  logic                       serr_nxt;
  logic [dcs_pkg::DATA_W-1:0] rdata_r;
  logic [dcs_pkg::DATA_W-1:0] rdata_nxt;
  logic [dcs_pkg::DATA_W-1:0] state_word;

  // launch is a setup write with the start bit high
  always_comb begin
    wr_state  = wr && (addr == dcs_pkg::OFF_STATE);
    wr_setup  = wr && (addr == dcs_pkg::OFF_SETUP);
    start_req = wr_setup && wdata[dcs_pkg::START_BIT];
    any_err   = src_bus_err_i || dst_bus_err_i || cfg_err_i;
    // an error in the same cycle as the end turns it abnormal
    done_ok   = xfer_done_i && live_r && !any_err;
    // a pending done flag blocks the launch; software must clear both first
    start_err = start_req && (flag_q[dcs_pkg::FLAG_NC] || flag_q[dcs_pkg::FLAG_ABC]);
    start_ok  = start_req && !start_err && !live_r && !any_err;
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // writes of one to the done flags store nothing; zero clears
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[dcs_pkg::FLAG_NC]  = done_ok;
    flag_set[dcs_pkg::FLAG_ABC] = any_err;
    flag_set[dcs_pkg::FLAG_SBE] = src_bus_err_i;
    flag_set[dcs_pkg::FLAG_DBE] = dst_bus_err_i;
    flag_set[dcs_pkg::FLAG_CFG] = cfg_err_i;
    flag_clr[dcs_pkg::FLAG_NC]  = wr_state && !wdata[dcs_pkg::NC_BIT];
    flag_clr[dcs_pkg::FLAG_ABC] = wr_state && !wdata[dcs_pkg::ABC_BIT];
    flag_clr[dcs_pkg::FLAG_SBE] = flag_clr[dcs_pkg::FLAG_ABC];
    flag_clr[dcs_pkg::FLAG_DBE] = flag_clr[dcs_pkg::FLAG_ABC];
    flag_clr[dcs_pkg::FLAG_CFG] = flag_clr[dcs_pkg::FLAG_ABC];
  end

  // one sticky cell per flag
  generate
    for (genvar i = 0; i < dcs_pkg::NUM_FLAGS; i++) begin : g_flag
      dcs_flag u_flag (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .set     (flag_set[i]),
        .clr     (flag_clr[i]),
        .q       (flag_q[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // channel live state and control
  // ----------------------------------------------------------------
  // errors win over everything so a faulted channel never stays live
  always_comb begin
    live_nxt   = live_r;
    nc_ie_nxt  = nc_ie_r;
    abc_ie_nxt = abc_ie_r;
    if (any_err) begin
      live_nxt = 1'b0;
    end else if (done_ok) begin
      live_nxt = 1'b0;
    end else if (start_ok) begin
      live_nxt = 1'b1;
    end
    if (wr_setup) begin
      nc_ie_nxt  = wdata[dcs_pkg::NC_IE_BIT];
      abc_ie_nxt = wdata[dcs_pkg::ABC_IE_BIT];
    end
    start_nxt = start_ok;
    stop_nxt  = any_err && live_r;
    serr_nxt  = start_err;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      live_r   <= 1'b0;
      nc_ie_r  <= 1'b0;
      abc_ie_r <= 1'b0;
      start_r  <= 1'b0;
      stop_r   <= 1'b0;
      serr_r   <= 1'b0;
    end else begin
      live_r   <= live_nxt;
      nc_ie_r  <= nc_ie_nxt;
      abc_ie_r <= abc_ie_nxt;
      start_r  <= start_nxt;
      stop_r   <= stop_nxt;
      serr_r   <= serr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // done requests follow their flags, so clearing a flag withdraws them
  always_comb begin
    ev                        = '0;
    ev[dcs_pkg::EV_NORMAL]    = done_ok;
    ev[dcs_pkg::EV_ABNORMAL]  = any_err;
    ev[dcs_pkg::EV_START_ERR] = start_err;
    lvl_req = (flag_set[dcs_pkg::FLAG_NC] || (flag_q[dcs_pkg::FLAG_NC]
                 && !flag_clr[dcs_pkg::FLAG_NC])) && nc_ie_nxt;
    lvl_req = lvl_req || ((flag_set[dcs_pkg::FLAG_ABC] || (flag_q[dcs_pkg::FLAG_ABC]
                 && !flag_clr[dcs_pkg::FLAG_ABC])) && abc_ie_nxt);
  end

  dcs_irq #(
    .N (dcs_pkg::NUM_EV)
  ) u_irq (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ev      (ev),
    .wr_stat (wr && (addr == dcs_pkg::OFF_EV_STAT)),
    .wr_mask (wr && (addr == dcs_pkg::OFF_EV_MASK)),
    .wdata   (wdata[dcs_pkg::NUM_EV-1:0]),
    .lvl_req (lvl_req),
    .stat_o  (ev_stat),
    .mask_o  (ev_mask),
    .irq_o   (irq_w)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // reserved bits read zero whatever software wrote to them
  always_comb begin
    state_word                    = dcs_pkg::STATE_RESET;
    state_word[dcs_pkg::LIVE_BIT] = live_r;
    state_word[dcs_pkg::NC_BIT]   = flag_q[dcs_pkg::FLAG_NC];
    state_word[dcs_pkg::ABC_BIT]  = flag_q[dcs_pkg::FLAG_ABC];
    state_word[dcs_pkg::SBE_BIT]  = flag_q[dcs_pkg::FLAG_SBE];
    state_word[dcs_pkg::DBE_BIT]  = flag_q[dcs_pkg::FLAG_DBE];
    state_word[dcs_pkg::CFG_BIT]  = flag_q[dcs_pkg::FLAG_CFG];
    rdata_nxt = '0;
    if (rd) begin
      case (addr)
        dcs_pkg::OFF_STATE: begin
          rdata_nxt = state_word;
        end
        dcs_pkg::OFF_SETUP: begin
          rdata_nxt[dcs_pkg::NC_IE_BIT]  = nc_ie_r;
          rdata_nxt[dcs_pkg::ABC_IE_BIT] = abc_ie_r;
        end
        dcs_pkg::OFF_EV_STAT: begin
          rdata_nxt[dcs_pkg::NUM_EV-1:0] = ev_stat;
        end
        dcs_pkg::OFF_EV_MASK: begin
          rdata_nxt[dcs_pkg::NUM_EV-1:0] = ev_mask;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata       = rdata_r;
  assign start_o     = start_r;
  assign stop_o      = stop_r;
  assign start_err_o = serr_r;
  assign chan_live_o = live_r;
  assign irq_o       = irq_w;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // every check below is held off while reset is low by the default disable
  live_start_a : assert property (start_ok |=> live_r && start_r)
    else $error("accepted start did not make channel live");
  nc_set_a : assert property (done_ok |=> flag_q[dcs_pkg::FLAG_NC] && !live_r)
    else $error("normal end did not set normal-done flag");
  nc_clear_a : assert property (
      flag_clr[dcs_pkg::FLAG_NC] && !done_ok |=> !flag_q[dcs_pkg::FLAG_NC])
    else $error("write of zero did not clear normal-done flag");
  nc_keep_a : assert property (
      wr_state && wdata[dcs_pkg::NC_BIT] && !done_ok
      |=> flag_q[dcs_pkg::FLAG_NC] == $past(flag_q[dcs_pkg::FLAG_NC]))
    else $error("write of one changed normal-done flag");
  start_block_a : assert property (
      start_req && (flag_q[dcs_pkg::FLAG_NC] || flag_q[dcs_pkg::FLAG_ABC])
      |=> !start_r && start_err_o && live_r == $past(live_r))
    else $error("start went ahead with a done flag pending");
  // done flags only rise in a cycle that leaves live low, so a pending flag means idle
  live_idle_a : assert property (
      flag_q[dcs_pkg::FLAG_NC] || flag_q[dcs_pkg::FLAG_ABC] |-> !live_r)
    else $error("channel live with a done flag pending");
  refuse_quiet_a : assert property (start_err_o |-> !start_o && !chan_live_o)
    else $error("refused start still launched the channel");
  abc_set_a : assert property (any_err |=> flag_q[dcs_pkg::FLAG_ABC])
    else $error("error did not set abnormal-done flag");
  abc_irq_a : assert property (flag_q[dcs_pkg::FLAG_ABC] && abc_ie_r |-> irq_o)
    else $error("abnormal-done interrupt missing");
  err_clear_a : assert property (
      flag_clr[dcs_pkg::FLAG_ABC] && !any_err
      |=> !flag_q[dcs_pkg::FLAG_ABC]
      && flag_q[dcs_pkg::FLAG_CFG:dcs_pkg::FLAG_SBE] == 3'b000)
    else $error("abnormal clear left a flag set");
  // error flags are read-only: a write of ones must never raise them
  err_ro_a : assert property (
      !any_err && flag_q[dcs_pkg::FLAG_CFG:dcs_pkg::FLAG_SBE] == 3'b000
      |=> flag_q[dcs_pkg::FLAG_CFG:dcs_pkg::FLAG_SBE] == 3'b000)
    else $error("error flag rose without an error");
  src_err_a : assert property (src_bus_err_i |=> flag_q[dcs_pkg::FLAG_SBE])
    else $error("source bus error not recorded");
  dst_err_a : assert property (dst_bus_err_i |=> flag_q[dcs_pkg::FLAG_DBE])
    else $error("destination bus error not recorded");
  cfg_err_a : assert property (cfg_err_i |=> flag_q[dcs_pkg::FLAG_CFG])
    else $error("configuration error not recorded");
  err_stop_a : assert property (
      any_err && live_r |=> !live_r && stop_o ##1 !stop_o)
    else $error("error did not stop the channel for one cycle");
  nc_irq_a : assert property (flag_q[dcs_pkg::FLAG_NC] && nc_ie_r |-> irq_o)
    else $error("normal-done interrupt missing");
  read_state_a : assert property (
      rd && addr == dcs_pkg::OFF_STATE
      |=> rdata[dcs_pkg::LIVE_BIT] == $past(live_r) && rdata[21] == 1'b0)
    else $error("state read returned wrong live bit");

endmodule

`default_nettype wire

// file: tb_top.sv
// self-checking testbench for the dma channel status block
`timescale 1ns/100ps
`default_nettype none

module tb_top;

  // ----------------------------------------------------------------
  // clock, reset and stimulus signals
  // ----------------------------------------------------------------
  logic                       ref_clk     = 1'b0;
  logic                       rstn        = 1'b0;
  logic [dcs_pkg::ADDR_W-1:0] addr        = 8'h00;
  logic [dcs_pkg::DATA_W-1:0] wdata       = 32'h0000_0000;
  logic                       wr          = 1'b0;
  logic                       rd          = 1'b0;
  logic [3:0]                 ev_drv      = 4'h0;  // done, src, dst, cfg
  logic [dcs_pkg::DATA_W-1:0] rdata;
  logic                       start_o;
  logic                       stop_o;
  logic                       start_err_o;
  logic                       chan_live_o;
  logic                       irq_o;
  int                         num_errors;
  int                         samples_checked;

  dcs_channel dut (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .addr          (addr),
    .wdata         (wdata),
    .wr            (wr),
    .rd            (rd),
    .rdata         (rdata),
    .xfer_done_i   (ev_drv[0]),
    .src_bus_err_i (ev_drv[1]),
    .dst_bus_err_i (ev_drv[2]),
    .cfg_err_i     (ev_drv[3]),
    .start_o       (start_o),
    .stop_o        (stop_o),
    .start_err_o   (start_err_o),
    .chan_live_o   (chan_live_o),
    .irq_o         (irq_o)
  );

  // 10 mhz clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one-cycle write; returns on the edge that samples it
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr    <= 1'b0;
    #1;
  endtask

  // one-cycle read; data stand only in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, exp, what);
  endtask

  // one-cycle sequencer pulse
  task automatic pulse(input logic [3:0] v);
    @(posedge ref_clk);
    ev_drv <= v;
    @(posedge ref_clk);
    ev_drv <= 4'h0;
    #1;
  endtask

  // irq is registered on the same edge as the flag; allow two edges to land anyway
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({27'h0, chan_live_o, irq_o, start_o, stop_o, start_err_o}, 32'h0, "outputs at reset");
    rd_chk(8'h00, 32'h0000_0000, "state reset value");
    // read-only bits and done flags must ignore ones; reserved bits kept 0
    wr_reg(8'h00, 32'h80dc_0000);
    rd_chk(8'h00, 32'h0000_0000, "state after writing ones");
    rd_chk(8'h10, 32'h0000_0000, "unmapped read");
    // read data stand for one cycle only, then fall back to zero
    rd_chk(8'h00, 32'h0000_0000, "state read before idle");
    @(posedge ref_clk);
    #1;
    chk(rdata, 32'h0000_0000, "read data gone after one cycle");
    $display("test reset done, errors %0d", num_errors);
  endtask

  task automatic t_normal();
    wr_reg(8'h04, 32'h0000_0003);
    chk({30'h0, start_o, chan_live_o}, 32'h3, "start accepted");
    rd_chk(8'h00, 32'h8000_0000, "live flag while running");
    chk({31'h0, start_o}, 32'h0, "start pulse one cycle");
    pulse(4'h1);
    chk({30'h0, chan_live_o, stop_o}, 32'h0, "live drops on normal end");
    rd_chk(8'h00, 32'h0080_0000, "normal done set");
    settle();
    chk({31'h0, irq_o}, 32'h1, "normal done irq");
    wr_reg(8'h00, 32'h0080_0000);
    rd_chk(8'h00, 32'h0080_0000, "writing one keeps normal done");
    wr_reg(8'h04, 32'h0000_0003);
    chk({29'h0, start_err_o, start_o, chan_live_o}, 32'h4, "start refused on normal done");
    wr_reg(8'h00, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000, "normal done cleared");
    settle();
    chk({31'h0, irq_o}, 32'h0, "normal irq withdrawn");
    $display("test normal done, errors %0d", num_errors);
  endtask

  task automatic t_errors();
    logic [31:0] flag;
    for (int i = 0; i < 3; i++) begin
      flag = 32'h0010_0000 >> i;  // source, destination, configuration fault
      wr_reg(8'h04, 32'h0000_0005);
      chk({30'h0, start_o, chan_live_o}, 32'h3, "start before error");
      pulse(4'h2 << i);
      chk({30'h0, stop_o, chan_live_o}, 32'h2, "error stops channel");
      rd_chk(8'h00, 32'h0040_0000 | flag, "error flags");
      settle();
      chk({31'h0, irq_o}, 32'h1, "abnormal done irq");
      wr_reg(8'h04, 32'h0000_0005);
      chk({29'h0, start_err_o, start_o, chan_live_o}, 32'h4, "start refused on abnormal");
      wr_reg(8'h00, 32'h0040_0000);
      rd_chk(8'h00, 32'h0040_0000 | flag, "writing one keeps abnormal");
      wr_reg(8'h00, 32'h0000_0000);
      rd_chk(8'h00, 32'h0000_0000, "abnormal clear takes errors");
      settle();
      chk({31'h0, irq_o}, 32'h0, "abnormal irq cancelled");
    end
    $display("test errors done, errors %0d", num_errors);
  endtask

  // sticky events from earlier tests, masked into the level output
  task automatic t_events();
    rd_chk(8'h04, 32'h0000_0004, "setup start bit reads 0");
    rd_chk(8'h08, 32'h0000_0007, "event status sticky");
    settle();
    chk({31'h0, irq_o}, 32'h0, "masked events quiet");
    wr_reg(8'h0c, 32'h0000_0004);
    rd_chk(8'h0c, 32'h0000_0004, "mask readback");
    settle();
    chk({31'h0, irq_o}, 32'h1, "unmasked event irq");
    wr_reg(8'h08, 32'h0000_0007);
    rd_chk(8'h08, 32'h0000_0000, "event write one clears");
    settle();
    chk({31'h0, irq_o}, 32'h0, "irq after event clear");
    $display("test events done, errors %0d", num_errors);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // the whole run needs about 120 cycles; cut off well beyond that
  initial begin
    #(100 * 5000);
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    summarize();
  end

  initial begin
    num_errors      = 0;
    samples_checked = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_normal();
    t_errors();
    t_events();
    summarize();
  end

endmodule
`default_nettype wire
